// *** dpa_parallel_adapter.sv ***
`timescale 1ns/1ps
`include "dpa_params.svh"

module dpa_parallel_adapter (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic enable_strobe_i,
  input wire logic read_not_write_i,
  input wire logic select_pos_first_i,
  input wire logic select_pos_second_i,
  input wire logic select_neg_n_i,
  input wire logic reg_select_lo_i,
  input wire logic reg_select_hi_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [7:0] port_a_lines_i,
  output logic [7:0] port_a_lines_o,
  output logic [7:0] port_a_lines_oe_n_o,
  input wire logic [7:0] port_b_lines_i,
  output logic [7:0] port_b_lines_o,
  output logic [7:0] port_b_lines_oe_n_o,
  input wire logic side_a_irq_input_i,
  input wire logic side_b_irq_input_i,
  input wire logic side_a_control_line_i,
  output logic side_a_control_line_o,
  output logic side_a_control_line_oe_n_o,
  input wire logic side_b_control_line_i,
  output logic side_b_control_line_o,
  output logic side_b_control_line_oe_n_o,
  input wire logic side_a_irq_out_n_i,
  output logic side_a_irq_out_n_o,
  output logic side_a_irq_out_n_oe_n_o,
  input wire logic side_b_irq_out_n_i,
  output logic side_b_irq_out_n_o,
  output logic side_b_irq_out_n_oe_n_o
);
  import dpa_pkg::*;

  localparam int SW = `DPA_SYNC_W;

  logic [SW-1:0] raw_w;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;
  logic [SW-1:0] filt_q;
  logic [SW-1:0] filt_d;

  logic e_f;
  logic rw_f;
  logic sel_f;
  logic [1:0] rs_f;
  logic [7:0] bus_f;
  logic [7:0] pin_f [2];
  logic [1:0] line1_f;
  logic [1:0] line2_f;

  dpa_bus_state_t state_q;
  logic cyc_sel_q;
  logic cyc_rw_q;
  logic [1:0] cyc_rs_q;
  logic [7:0] wdata_q;
  logic commit_w;

  logic [7:0] ctrl_q [2];
  logic [7:0] out_q [2];
  logic [7:0] dir_q [2];
  logic [1:0] arm1_q;
  logic [1:0] arm2_q;
  logic [1:0] line1_prev_q;
  logic [1:0] line2_prev_q;
  logic [1:0] edge1_w;
  logic [1:0] edge2_w;
  logic [1:0] rd_clr_w;
  logic [1:0] wr_data_w;
  logic [1:0] wr_ctrl_w;
  logic [1:0] irq_w;
  logic [1:0] irq_q;
  logic [1:0] line2_o_q;
  logic [7:0] rd_mux_w;
  logic [7:0] data_q;
  logic data_oe_n_q;

  // pins cross into mclk through three flops each
  assign raw_w = {side_b_control_line_i, side_a_control_line_i, side_b_irq_input_i, side_a_irq_input_i,
                  port_b_lines_i, port_a_lines_i, data_i, reg_select_hi_i, reg_select_lo_i,
                  select_neg_n_i, select_pos_second_i, select_pos_first_i, read_not_write_i,
                  enable_strobe_i};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a bit moves only once stages two and three agree
  assign filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  assign e_f = filt_q[0];
  assign rw_f = filt_q[1];
  assign sel_f = filt_q[2] & filt_q[3] & ~filt_q[4];
  assign rs_f = filt_q[6:5];
  assign bus_f = filt_q[14:7];
  assign pin_f[0] = filt_q[22:15];
  assign pin_f[1] = filt_q[30:23];
  assign line1_f = filt_q[32:31];
  assign line2_f = filt_q[34:33];

  // selects and register selects taken at the strobe's leading edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= DPA_BUS_IDLE;
      cyc_sel_q <= 1'b0;
      cyc_rw_q <= 1'b0;
      cyc_rs_q <= 2'h0;
    end else begin
      case (state_q)
        DPA_BUS_IDLE: begin
          if (e_f) begin
            state_q <= DPA_BUS_ACCESS;
            cyc_sel_q <= sel_f;
            cyc_rw_q <= rw_f;
            cyc_rs_q <= rs_f;
          end
        end
        DPA_BUS_ACCESS: begin
          if (!e_f) begin
            state_q <= DPA_BUS_IDLE;
          end
        end
        default: begin
          state_q <= DPA_BUS_IDLE;
        end
      endcase
    end
  end

  // write data tracks the bus while the strobe is high; zero hold time
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdata_q <= 8'h00;
    end else if (e_f) begin
      wdata_q <= bus_f;
    end
  end

  assign commit_w = (state_q == DPA_BUS_ACCESS) && !e_f;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      assign wr_data_w[s] = commit_w && cyc_sel_q && !cyc_rw_q && (cyc_rs_q == {s[0], 1'b0});
      assign wr_ctrl_w[s] = commit_w && cyc_sel_q && !cyc_rw_q && (cyc_rs_q == {s[0], 1'b1});
      assign rd_clr_w[s] = commit_w && cyc_sel_q && cyc_rw_q && (cyc_rs_q == {s[0], 1'b0}) &&
                           ctrl_q[s][`DPA_CB_ACCESS];
      assign edge1_w[s] = ctrl_q[s][`DPA_CB_IRQ1_POL] ? (line1_f[s] & ~line1_prev_q[s]) :
                                                        (~line1_f[s] & line1_prev_q[s]);
      assign edge2_w[s] = ctrl_q[s][`DPA_CB_LINE2_POL] ? (line2_f[s] & ~line2_prev_q[s]) :
                                                         (~line2_f[s] & line2_prev_q[s]);
      assign irq_w[s] = (ctrl_q[s][`DPA_CB_FLAG1] & ctrl_q[s][`DPA_CB_IRQ1_EN]) |
                        (ctrl_q[s][`DPA_CB_FLAG2] & ctrl_q[s][`DPA_CB_LINE2_CTL] & ~ctrl_q[s][`DPA_CB_LINE2_OUT]);

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          out_q[s] <= `DPA_REG_RESET;
          dir_q[s] <= `DPA_REG_RESET;
        end else if (wr_data_w[s]) begin
          if (ctrl_q[s][`DPA_CB_ACCESS]) begin
            out_q[s] <= wdata_q;
          end else begin
            dir_q[s] <= wdata_q;
          end
        end
      end

      // secondary flag only as input
      // set beats a same-cycle read clear
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ctrl_q[s] <= `DPA_REG_RESET;
        end else begin
          if (wr_ctrl_w[s]) begin
            ctrl_q[s][5:0] <= wdata_q[5:0];
          end
          if (edge1_w[s] && arm1_q[s]) begin
            ctrl_q[s][`DPA_CB_FLAG1] <= 1'b1;
          end else if (rd_clr_w[s]) begin
            ctrl_q[s][`DPA_CB_FLAG1] <= 1'b0;
          end
          if (edge2_w[s] && arm2_q[s] && !ctrl_q[s][`DPA_CB_LINE2_OUT]) begin
            ctrl_q[s][`DPA_CB_FLAG2] <= 1'b1;
          end else if (rd_clr_w[s]) begin
            ctrl_q[s][`DPA_CB_FLAG2] <= 1'b0;
          end
        end
      end

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          arm1_q[s] <= 1'b1;
          arm2_q[s] <= 1'b1;
        end else if (rd_clr_w[s]) begin
          arm1_q[s] <= 1'b0;
          arm2_q[s] <= 1'b0;
        end else if (commit_w && !cyc_sel_q) begin
          arm1_q[s] <= 1'b1;
          arm2_q[s] <= 1'b1;
        end
      end

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          line1_prev_q[s] <= 1'b0;
          line2_prev_q[s] <= 1'b0;
        end else begin
          line1_prev_q[s] <= line1_f[s];
          line2_prev_q[s] <= line2_f[s];
        end
      end

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          irq_q[s] <= 1'b0;
          line2_o_q[s] <= 1'b0;
        end else begin
          irq_q[s] <= irq_w[s];
          line2_o_q[s] <= ctrl_q[s][`DPA_CB_LINE2_CTL];
        end
      end
    end
  endgenerate

  always_comb begin
    case (rs_f)
      `DPA_RS_PORT_A: rd_mux_w = ctrl_q[0][`DPA_CB_ACCESS] ? pin_f[0] : dir_q[0];
      `DPA_RS_CTRL_A: rd_mux_w = ctrl_q[0];
      `DPA_RS_PORT_B: rd_mux_w = ctrl_q[1][`DPA_CB_ACCESS] ? ((out_q[1] & dir_q[1]) | (pin_f[1] & ~dir_q[1])) :
                                                            dir_q[1];
      `DPA_RS_CTRL_B: rd_mux_w = ctrl_q[1];
      default: rd_mux_w = 8'h00;
    endcase
  end

  // drive bus only on selected read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_q <= 8'h00;
      data_oe_n_q <= 1'b1;
    end else begin
      data_q <= rd_mux_w;
      data_oe_n_q <= ~(e_f && sel_f && rw_f);
    end
  end

  assign data_o = data_q;
  assign data_oe_n_o = data_oe_n_q;
  assign port_a_lines_o = out_q[0];
  assign port_a_lines_oe_n_o = ~dir_q[0];
  assign port_b_lines_o = out_q[1];
  assign port_b_lines_oe_n_o = ~dir_q[1];
  assign side_a_control_line_o = line2_o_q[0];
  assign side_a_control_line_oe_n_o = ~ctrl_q[0][`DPA_CB_LINE2_OUT];
  assign side_b_control_line_o = line2_o_q[1];
  assign side_b_control_line_oe_n_o = ~ctrl_q[1][`DPA_CB_LINE2_OUT];
  // open-drain: value fixed low, enable carries the request
  assign side_a_irq_out_n_o = 1'b0;
  assign side_a_irq_out_n_oe_n_o = ~irq_q[0];
  assign side_b_irq_out_n_o = 1'b0;
  assign side_b_irq_out_n_oe_n_o = ~irq_q[1];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  dir_drives_pins_a: assert property (port_a_lines_oe_n_o == ~dir_q[0] && port_b_lines_oe_n_o == ~dir_q[1])
    else $error("port drivers disagree with direction");
  pin_read_a_a: assert property (rs_f == `DPA_RS_PORT_A && ctrl_q[0][`DPA_CB_ACCESS] |=> data_o == $past(pin_f[0]))
    else $error("side A read not from pins");
  latch_read_b_a: assert property (rs_f == `DPA_RS_PORT_B && ctrl_q[1][`DPA_CB_ACCESS]
      |=> (data_o & $past(dir_q[1])) == ($past(out_q[1]) & $past(dir_q[1])))
    else $error("side B output bits not from latch");
  flag_rearm_a: assert property (rd_clr_w[0] && !edge1_w[0] ##1 !(commit_w && !cyc_sel_q) [*2]
      |-> !ctrl_q[0][`DPA_CB_FLAG1])
    else $error("flag set before deselected strobe");
  flag_write_ro_a: assert property (wr_ctrl_w[1] && !edge1_w[1] && !edge2_w[1] && !rd_clr_w[1]
      |=> ctrl_q[1][7:6] == $past(ctrl_q[1][7:6]))
    else $error("flag bits changed by a write");
  ctrl_write_a: assert property (wr_ctrl_w[0] |=> ctrl_q[0][5:0] == $past(wdata_q[5:0]))
    else $error("control bits not written");
  read_clear_a: assert property (rd_clr_w[1] && !edge1_w[1] |=> !ctrl_q[1][`DPA_CB_FLAG1])
    else $error("data read left flag set");
  edge_sets_a: assert property (edge1_w[0] && arm1_q[0] |=> ctrl_q[0][`DPA_CB_FLAG1])
    else $error("active edge missed");
  out_mode_flag_a: assert property (ctrl_q[1][`DPA_CB_LINE2_OUT] && !ctrl_q[1][`DPA_CB_FLAG2] && !wr_ctrl_w[1]
      |=> !ctrl_q[1][`DPA_CB_FLAG2])
    else $error("secondary flag set in output mode");
  irq_enable_a: assert property (ctrl_q[0][`DPA_CB_FLAG1] && ctrl_q[0][`DPA_CB_IRQ1_EN]
      |=> !side_a_irq_out_n_oe_n_o)
    else $error("enabled flag did not pull request");
  bus_drive_a: assert property (!data_oe_n_o |-> $past(e_f && sel_f && rw_f))
    else $error("data bus driven outside a read");

endmodule

// *** dpa_params.svh ***
`ifndef DPA_PARAMS_SVH
`define DPA_PARAMS_SVH

// register select codes {reg_select_hi, reg_select_lo}
`define DPA_RS_PORT_A 2'h0
`define DPA_RS_CTRL_A 2'h1
`define DPA_RS_PORT_B 2'h2
`define DPA_RS_CTRL_B 2'h3

// control register field positions
`define DPA_CB_IRQ1_EN 0
`define DPA_CB_IRQ1_POL 1
`define DPA_CB_ACCESS 2
`define DPA_CB_LINE2_CTL 3
`define DPA_CB_LINE2_POL 4
`define DPA_CB_LINE2_OUT 5
`define DPA_CB_FLAG2 6
`define DPA_CB_FLAG1 7

// reset value and writable part of a control register
`define DPA_REG_RESET 8'h00
`define DPA_CTRL_WR_MASK 8'h3F

// synchronised pin count: strobe, rw, 3 selects, 2 reg selects, data, ports, 4 side lines
`define DPA_SYNC_W 35

`endif

// *** dpa_periph_model.sv ***
`timescale 1ns/1ps
// peripheral-side pin model: resolves both ports from every driver
module dpa_periph_model (
  input wire logic mclk_i,
  input wire logic load_i,
  input wire logic [7:0] a_drv_i,
  input wire logic [7:0] a_oe_n_i,
  input wire logic [7:0] b_drv_i,
  input wire logic [7:0] b_oe_n_i,
  input wire logic [7:0] ext_a_i,
  input wire logic [7:0] ext_b_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] a_pin_o,
  output logic [7:0] b_pin_o
);
  logic [7:0] b_last_q;
  // remember only resolved levels; a floating line drifts away from them
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en_i[i] || !b_oe_n_i[i]) b_last_q[i] <= b_pin_o[i];
    end
  end
  // heavy load can pull a driven line
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en_i[i] && (load_i || a_oe_n_i[i])) a_pin_o[i] = ext_a_i[i];
      else if (!a_oe_n_i[i]) a_pin_o[i] = a_drv_i[i];
      else a_pin_o[i] = 1'b1;
      if (ext_en_i[i] && (load_i || b_oe_n_i[i])) b_pin_o[i] = ext_b_i[i];
      else if (!b_oe_n_i[i]) b_pin_o[i] = b_drv_i[i];
      else b_pin_o[i] = (b_last_q[i] === 1'b1) ? 1'b0 : 1'b1;
    end
  end
endmodule

// *** dpa_pkg.sv ***
package dpa_pkg;

  typedef enum logic [0:0] {
    DPA_BUS_IDLE = 1'b0,
    DPA_BUS_ACCESS = 1'b1
  } dpa_bus_state_t;

endpackage

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_b, stb, rw, cs1, cs2, csn, load;
  logic [1:0] rs, irq1, ext_c;
  logic [7:0] dbus, rdata, ext_a, ext_b, ext_en;
  logic [7:0] d_o, a_o, a_oe, b_o, b_oe, a_pin, b_pin;
  logic d_oe, ca_o, ca_oe, cb_o, cb_oe, ia_o, ia_oe, ib_o, ib_oe;
  int fail_count = 0;
  int checks = 0;
  wire ca_pin = ca_oe ? ext_c[0] : ca_o;
  wire cb_pin = cb_oe ? ext_c[1] : cb_o;
  // open-drain requests with pull-up
  wire ia_w = ia_oe ? 1'b1 : ia_o;
  wire ib_w = ib_oe ? 1'b1 : ib_o;
  dpa_parallel_adapter i_dut (.mclk_i(mclk), .rst_b_i(rst_b), .enable_strobe_i(stb),
    .read_not_write_i(rw), .select_pos_first_i(cs1), .select_pos_second_i(cs2),
    .select_neg_n_i(csn), .reg_select_lo_i(rs[0]), .reg_select_hi_i(rs[1]), .data_i(dbus),
    .data_o(d_o), .data_oe_n_o(d_oe), .port_a_lines_i(a_pin), .port_a_lines_o(a_o),
    .port_a_lines_oe_n_o(a_oe), .port_b_lines_i(b_pin), .port_b_lines_o(b_o),
    .port_b_lines_oe_n_o(b_oe), .side_a_irq_input_i(irq1[0]), .side_b_irq_input_i(irq1[1]),
    .side_a_control_line_i(ca_pin), .side_a_control_line_o(ca_o),
    .side_a_control_line_oe_n_o(ca_oe), .side_b_control_line_i(cb_pin),
    .side_b_control_line_o(cb_o), .side_b_control_line_oe_n_o(cb_oe),
    .side_a_irq_out_n_i(ia_w), .side_a_irq_out_n_o(ia_o), .side_a_irq_out_n_oe_n_o(ia_oe),
    .side_b_irq_out_n_i(ib_w), .side_b_irq_out_n_o(ib_o), .side_b_irq_out_n_oe_n_o(ib_oe));
  dpa_periph_model i_pins (.mclk_i(mclk), .load_i(load), .a_drv_i(a_o), .a_oe_n_i(a_oe),
    .b_drv_i(b_o), .b_oe_n_i(b_oe), .ext_a_i(ext_a), .ext_b_i(ext_b), .ext_en_i(ext_en),
    .a_pin_o(a_pin), .b_pin_o(b_pin));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // strobe long enough for the pin filter; selects held until the next access
  task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] wd, input logic sel);
    rw = r;
    rs = a;
    dbus = wd;
    cs1 = sel;
    stb = 1'b1;
    pause(7);
    rdata = d_o;
    if (r) chk("bus drive", {7'h0, d_oe}, {7'h0, ~sel});
    stb = 1'b0;
    pause(7);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] wd);
    acc(1'b0, a, wd, 1'b1);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string name);
    acc(1'b1, a, 8'h00, 1'b1);
    chk(name, rdata, exp);
  endtask
  function automatic logic [7:0] irq_oe(input int s);
    return {7'h0, s ? ib_w : ia_w};
  endfunction
  task automatic irq_side(input int s);
    logic [1:0] c;
    logic [1:0] d;
    c = s ? 2'h3 : 2'h1;
    d = s ? 2'h2 : 2'h0;
    acc(1'b0, d, 8'h00, 1'b0);
    wr(c, 8'h07);
    irq1[s] = 1'b1;
    pause(8);
    rd(c, 8'h87, "first flag");
    chk("irq on", irq_oe(s), 8'h00);
    acc(1'b1, d, 8'h00, 1'b1);
    rd(c, 8'h07, "read clear");
    chk("irq off", irq_oe(s), 8'h01);
    irq1[s] = 1'b0;
    pause(8);
    irq1[s] = 1'b1;
    pause(8);
    rd(c, 8'h07, "disarmed");
    acc(1'b0, d, 8'h00, 1'b0);
    wr(c, 8'h05);
    irq1[s] = 1'b0;
    pause(8);
    rd(c, 8'h85, "falling edge");
    acc(1'b1, d, 8'h00, 1'b1);
    acc(1'b0, d, 8'h00, 1'b0);
    wr(c, 8'h1C);
    ext_c[s] = 1'b1;
    pause(8);
    rd(c, 8'h5C, "second flag");
    chk("irq second", irq_oe(s), 8'h00);
    acc(1'b1, d, 8'h00, 1'b1);
    acc(1'b0, d, 8'h00, 1'b0);
    wr(c, 8'h34);
    chk("ctl low", {6'h0, s ? cb_oe : ca_oe, s ? cb_o : ca_o}, 8'h00);
    wr(c, 8'h3C);
    chk("ctl high", {6'h0, s ? cb_oe : ca_oe, s ? cb_o : ca_o}, 8'h01);
    rd(c, 8'h3C, "output no flag");
    wr(c, 8'h00);
    $display("test irq side %0d done", s);
  endtask
  initial begin
    #(6000 * 50);
    fail_count++;
    give_verdict();
  end
  initial begin
    {stb, rw, csn, load, rs, irq1, ext_c} = '0;
    {dbus, ext_a, ext_b, ext_en} = '0;
    cs1 = 1'b1;
    cs2 = 1'b1;
    rst_b = 1'b0;
    pause(12);
    rst_b = 1'b1;
    pause(5);
    chk("idle lines", a_oe & b_oe, 8'hFF);
    chk("bus idle", {7'h0, d_oe}, 8'h01);
    chk("ctl oe", {6'h0, ca_oe, cb_oe}, 8'h03);
    rd(2'h1, 8'h00, "ctrl a rst");
    rd(2'h3, 8'h00, "ctrl b rst");
    rd(2'h0, 8'h00, "dir a rst");
    rd(2'h2, 8'h00, "dir b rst");
    $display("test reset done");
    wr(2'h0, 8'hF0);
    wr(2'h2, 8'hF0);
    wr(2'h1, 8'h04);
    wr(2'h3, 8'h04);
    wr(2'h0, 8'hA5);
    wr(2'h2, 8'h5A);
    rd(2'h1, 8'h04, "ctrl a rw");
    chk("a drive", a_oe, 8'h0F);
    chk("b release", b_oe, 8'h0F);
    chk("a out", a_o, 8'hA5);
    chk("b out", b_o, 8'h5A);
    ext_a = 8'h03;
    ext_b = 8'h0C;
    ext_en = 8'h0F;
    pause(6);
    rd(2'h0, 8'hA3, "port a mix");
    rd(2'h2, 8'h5C, "port b mix");
    load = 1'b1;
    ext_a = 8'h33;
    ext_b = 8'h33;
    ext_en = 8'hFF;
    pause(6);
    rd(2'h0, 8'h33, "port a pin");
    rd(2'h2, 8'h53, "port b latch");
    load = 1'b0;
    ext_en = 8'h0F;
    acc(1'b0, 2'h0, 8'hFF, 1'b0);
    chk("deselected", a_o, 8'hA5);
    wr(2'h3, 8'hDF);
    rd(2'h3, 8'h1F, "flag ro");
    wr(2'h3, 8'h00);
    $display("test ports done");
    irq_side(0);
    irq_side(1);
    give_verdict();
  end
endmodule
